// ---- bief_pkg.sv ----
package bief_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] MS_PER_TENTH = 7'h64;
  localparam logic [3:0] TENTHS_PER_SEC = 4'hA;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MINSIG = 8'h04;
  localparam logic [7:0] ADDR_WAIT = 8'h08;
  localparam logic [7:0] ADDR_CYCLE = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    BIEF_REACT_ON = 3'h0,
    BIEF_REACT_OFF = 3'h1,
    BIEF_REACT_TOGGLE = 3'h2,
    BIEF_REACT_NONE = 3'h3,
    BIEF_REACT_STOP = 3'h4
  } bief_react_t;

  typedef enum logic [1:0] {
    BIEF_CYC_ON_0 = 2'h0,
    BIEF_CYC_ON_1 = 2'h1,
    BIEF_CYC_ON_ANY = 2'h2
  } bief_cycval_t;

  typedef struct packed {
    logic [4:0] rsv_hi;
    bief_cycval_t cyc_val;
    bief_react_t react1;
    bief_react_t react0;
    logic [4:0] long_sel;
    logic [2:0] deb_sel;
    logic [3:0] rsv_lo;
    logic update_en;
    logic write_en;
    logic cyc_en;
    logic scan_en;
    logic minsig_en;
    logic contact_open;
    logic sl_en;
  } bief_ctrl_t;

  typedef struct packed {
    logic [26:0] rsv;
    logic cyc_stopped;
    logic waiting;
    logic pressing;
    logic level;
    logic value;
  } bief_status_t;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam bief_ctrl_t CTRL_RESET = '{
    rsv_hi: 5'h00, cyc_val: BIEF_CYC_ON_1, react1: BIEF_REACT_ON,
    react0: BIEF_REACT_OFF, long_sel: 5'h03, deb_sel: 3'h3,
    rsv_lo: 4'h0, update_en: 1'b0, write_en: 1'b0, cyc_en: 1'b0,
    scan_en: 1'b0, minsig_en: 1'b0, contact_open: 1'b0, sl_en: 1'b0};
  localparam logic [15:0] MINSIG_RESET = 16'h000A;
  localparam logic [14:0] WAIT_RESET = 15'h0000;
  localparam logic [15:0] CYCLE_RESET = 16'h003C;

  // Debounce time in ms: 10/20/30/50/70/100/150
  function automatic logic [7:0] deb_ms(input logic [2:0] sel);
    case (sel)
      3'h0: deb_ms = 8'h0A;
      3'h1: deb_ms = 8'h14;
      3'h2: deb_ms = 8'h1E;
      3'h3: deb_ms = 8'h32;
      3'h4: deb_ms = 8'h46;
      3'h5: deb_ms = 8'h64;
      default: deb_ms = 8'h96;
    endcase
  endfunction

  // Long threshold in ms: 0.3..0.8, 1, 1.2, 1.5, then 2..10 s
  function automatic logic [13:0] long_ms(input logic [4:0] sel);
    case (sel)
      5'h00: long_ms = 14'h012C;
      5'h01: long_ms = 14'h0190;
      5'h02: long_ms = 14'h01F4;
      5'h03: long_ms = 14'h0258;
      5'h04: long_ms = 14'h0320;
      5'h05: long_ms = 14'h03E8;
      5'h06: long_ms = 14'h04B0;
      5'h07: long_ms = 14'h05DC;
      default: long_ms = (sel > 5'h10) ? 14'h2710 :
        14'((sel - 5'h06) * 11'h3E8);
    endcase
  endfunction

endpackage

// ---- bief_top.sv ----
`timescale 1ns/1ps
module bief_top #(
  parameter int MS_CYCLES = bief_pkg::MS_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic CONTACT_IN,
  input wire logic CONFIG_LOADED,
  input wire logic BUS_RECOVERED,
  input wire logic SEND_DELAY_DONE,
  input wire logic OBJ_WRITE,
  input wire logic OBJ_UPDATE,
  input wire logic OBJ_VALUE_IN,
  output logic SEND,
  output logic SEND_VALUE,
  output logic SWITCH_VALUE
);

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  bief_pkg::bief_ctrl_t ctrl, next_ctrl;
  logic [15:0] min_close, next_min_close, min_open, next_min_open;
  logic [14:0] wait_sec, next_wait_sec;
  logic [15:0] cycle_sec, next_cycle_sec;
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  bief_pkg::bief_status_t status;
  logic req;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack;
  assign AVS_READDATA = rdata;

  always_comb begin
    next_ack = req & ~ack;
    next_ctrl = ctrl;
    next_min_close = min_close;
    next_min_open = min_open;
    next_wait_sec = wait_sec;
    next_cycle_sec = cycle_sec;
    next_rdata = rdata;
    if (next_ack) begin
      case (AVS_ADDRESS)
        bief_pkg::ADDR_CTRL: next_rdata = ctrl;
        bief_pkg::ADDR_MINSIG: next_rdata = {min_open, min_close};
        bief_pkg::ADDR_WAIT: next_rdata = {17'h00000, wait_sec};
        bief_pkg::ADDR_CYCLE: next_rdata = {16'h0000, cycle_sec};
        bief_pkg::ADDR_STATUS: next_rdata = status;
        default: next_rdata = 32'h00000000;
      endcase
    end
    if (AVS_WRITE & ack) begin
      case (AVS_ADDRESS)
        bief_pkg::ADDR_CTRL:
          next_ctrl = merge(ctrl, AVS_WRITEDATA, AVS_BYTEENABLE);
        bief_pkg::ADDR_MINSIG:
          {next_min_open, next_min_close} =
            merge({min_open, min_close}, AVS_WRITEDATA, AVS_BYTEENABLE);
        bief_pkg::ADDR_WAIT:
          next_wait_sec = 15'(merge({17'h00000, wait_sec}, AVS_WRITEDATA,
                                    AVS_BYTEENABLE));
        bief_pkg::ADDR_CYCLE:
          next_cycle_sec = 16'(merge({16'h0000, cycle_sec}, AVS_WRITEDATA,
                                     AVS_BYTEENABLE));
        default: next_ack = 1'b0;
      endcase
      next_ack = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack <= 1'b0;
      rdata <= 32'h00000000;
      ctrl <= bief_pkg::CTRL_RESET;
      min_close <= bief_pkg::MINSIG_RESET;
      min_open <= bief_pkg::MINSIG_RESET;
      wait_sec <= bief_pkg::WAIT_RESET;
      cycle_sec <= bief_pkg::CYCLE_RESET;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      ctrl <= next_ctrl;
      min_close <= next_min_close;
      min_open <= next_min_open;
      wait_sec <= next_wait_sec;
      cycle_sec <= next_cycle_sec;
    end
  end

  // ---------------------------------------------------------------
  // Input path, timers and switch object
  // ---------------------------------------------------------------
  logic sync1, sync2;
  logic [15:0] ms_cnt, next_ms_cnt;
  logic [6:0] tenth_cnt, next_tenth_cnt;
  logic [3:0] sec_cnt, next_sec_cnt;
  logic [7:0] deb_cnt, next_deb_cnt;
  logic level, next_level;
  logic [15:0] min_cnt, next_min_cnt;
  logic pend, next_pend, acc_level, next_acc_level;
  logic [13:0] press_cnt, next_press_cnt;
  logic pressing, next_pressing;
  logic waiting, next_waiting;
  logic [14:0] wait_cnt, next_wait_cnt;
  logic value, next_value, stopped, next_stopped;
  logic [15:0] cyc_cnt, next_cyc_cnt;
  logic send, next_send, send_val, next_send_val;
  logic ms_tick, tenth_tick, sec_tick;

  assign ms_tick = ms_cnt == 16'(MS_CYCLES - 1);
  assign tenth_tick = ms_tick & (tenth_cnt == bief_pkg::MS_PER_TENTH - 7'h01);
  assign sec_tick = tenth_tick &
                    (sec_cnt == bief_pkg::TENTHS_PER_SEC - 4'h1);
  assign status = '{rsv: 27'h0000000, cyc_stopped: stopped,
                    waiting: waiting, pressing: pressing, level: acc_level,
                    value: value};
  assign SEND = send;
  assign SEND_VALUE = send_val;
  assign SWITCH_VALUE = value;

  always_comb begin
    logic edge_det, valid, vlevel, scan, ev0, ev1, do_send, cyc_ok;
    bief_pkg::bief_react_t react;
    edge_det = 1'b0;
    valid = 1'b0;
    vlevel = level;
    scan = 1'b0;
    ev0 = 1'b0;
    ev1 = 1'b0;
    do_send = 1'b0;
    react = bief_pkg::BIEF_REACT_NONE;
    next_ms_cnt = ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
    next_tenth_cnt = tenth_cnt;
    next_sec_cnt = sec_cnt;
    if (ms_tick) begin
      next_tenth_cnt = tenth_tick ? 7'h00 : tenth_cnt + 7'h01;
    end
    if (tenth_tick) begin
      next_sec_cnt = sec_tick ? 4'h0 : sec_cnt + 4'h1;
    end
    // take edge at once, then blind for the debounce time
    next_deb_cnt = deb_cnt;
    next_level = level;
    if (deb_cnt != 8'h00) begin
      if (ms_tick) begin
        next_deb_cnt = deb_cnt - 8'h01;
      end
    end else if (sync2 != level) begin
      next_level = sync2;
      next_deb_cnt = bief_pkg::deb_ms(ctrl.deb_sel);
      edge_det = 1'b1;
    end
    next_min_cnt = min_cnt;
    next_pend = pend;
    if (edge_det & ctrl.minsig_en) begin
      next_min_cnt = sync2 ? min_close : min_open;
      next_pend = next_min_cnt != 16'h0000;
      valid = ~next_pend;
    end else if (edge_det) begin
      valid = 1'b1;
    end else if (pend & tenth_tick) begin
      next_min_cnt = min_cnt - 16'h0001;
      if (min_cnt <= 16'h0001) begin
        next_pend = 1'b0;
        valid = 1'b1;
      end
    end
    if (valid & (level_after(valid, next_level) == acc_level)) begin
      valid = 1'b0;
    end
    next_waiting = waiting;
    next_wait_cnt = wait_cnt;
    if (ctrl.scan_en & CONFIG_LOADED) begin
      scan = 1'b1;
    end
    if (ctrl.scan_en & BUS_RECOVERED) begin
      next_wait_cnt = wait_sec;
      next_waiting = wait_sec != 15'h0000;
      scan = scan | ~next_waiting;
    end else if (waiting & sec_tick) begin
      next_wait_cnt = wait_cnt - 15'h0001;
      if (wait_cnt <= 15'h0001) begin
        next_waiting = 1'b0;
        scan = 1'b1;
      end
    end
    valid = valid | scan;
    vlevel = next_level;
    next_acc_level = valid ? vlevel : acc_level;
    next_pressing = pressing;
    next_press_cnt = press_cnt;
    if (ctrl.sl_en) begin
      if (valid & (vlevel ^ ctrl.contact_open)) begin
        next_pressing = 1'b1;
        next_press_cnt = 14'h0000;
      end else if (valid & pressing) begin
        next_pressing = 1'b0;
        ev0 = 1'b1;
      end else if (pressing & ms_tick) begin
        next_press_cnt = press_cnt + 14'h0001;
        if (next_press_cnt >= bief_pkg::long_ms(ctrl.long_sel)) begin
          next_pressing = 1'b0;
          ev1 = 1'b1;
        end
      end
    end else begin
      next_pressing = 1'b0;
      // opening event 0, closing event 1
      ev0 = valid & ~vlevel;
      ev1 = valid & vlevel;
    end
    if (ev1) begin
      react = ctrl.react1;
    end else if (ev0) begin
      react = ctrl.react0;
    end
    next_value = value;
    next_stopped = stopped;
    case (react)
      bief_pkg::BIEF_REACT_ON: next_value = 1'b1;
      bief_pkg::BIEF_REACT_OFF: next_value = 1'b0;
      bief_pkg::BIEF_REACT_TOGGLE: next_value = ~value;
      bief_pkg::BIEF_REACT_STOP: next_stopped = ctrl.cyc_en;
      default: next_stopped = stopped;
    endcase
    if (react <= bief_pkg::BIEF_REACT_TOGGLE) begin
      do_send = 1'b1;
      next_stopped = 1'b0;
    end else if ((OBJ_WRITE & ctrl.write_en) |
                 (OBJ_UPDATE & ctrl.update_en)) begin
      next_value = OBJ_VALUE_IN;
      do_send = OBJ_VALUE_IN != value;
    end
    do_send = do_send | SEND_DELAY_DONE;
    cyc_ok = ctrl.cyc_en & ~next_stopped &
             ((ctrl.cyc_val == bief_pkg::BIEF_CYC_ON_ANY) |
              (next_value == ctrl.cyc_val[0]));
    next_cyc_cnt = cyc_cnt;
    if (do_send | ~cyc_ok) begin
      next_cyc_cnt = cycle_sec;
    end else if (sec_tick) begin
      if (cyc_cnt <= 16'h0001) begin
        do_send = 1'b1;
        next_cyc_cnt = cycle_sec;
      end else begin
        next_cyc_cnt = cyc_cnt - 16'h0001;
      end
    end
    next_send = do_send;
    next_send_val = do_send ? next_value : send_val;
  end

  function automatic logic level_after(input logic v, input logic l);
    return v ? l : 1'b0;
  endfunction

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      ms_cnt <= 16'h0000;
      tenth_cnt <= 7'h00;
      sec_cnt <= 4'h0;
      deb_cnt <= 8'h00;
      level <= 1'b0;
      min_cnt <= 16'h0000;
      pend <= 1'b0;
      acc_level <= 1'b0;
      press_cnt <= 14'h0000;
      pressing <= 1'b0;
      waiting <= 1'b0;
      wait_cnt <= 15'h0000;
      value <= 1'b0;
      stopped <= 1'b0;
      cyc_cnt <= bief_pkg::CYCLE_RESET;
      send <= 1'b0;
      send_val <= 1'b0;
    end else begin
      sync1 <= CONTACT_IN;
      sync2 <= sync1;
      ms_cnt <= next_ms_cnt;
      tenth_cnt <= next_tenth_cnt;
      sec_cnt <= next_sec_cnt;
      deb_cnt <= next_deb_cnt;
      level <= next_level;
      min_cnt <= next_min_cnt;
      pend <= next_pend;
      acc_level <= next_acc_level;
      press_cnt <= next_press_cnt;
      pressing <= next_pressing;
      waiting <= next_waiting;
      wait_cnt <= next_wait_cnt;
      value <= next_value;
      stopped <= next_stopped;
      cyc_cnt <= next_cyc_cnt;
      send <= next_send;
      send_val <= next_send_val;
    end
  end

endmodule

// ---- bief_asserts.sv ----
`timescale 1ns/1ps
module bief_asserts (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic AVS_WAITREQUEST,
  input wire logic OBJ_WRITE,
  input wire logic OBJ_UPDATE,
  input wire logic OBJ_VALUE_IN,
  input wire logic SEND,
  input wire logic SEND_VALUE,
  input wire logic SWITCH_VALUE
);
  // ------------------------------------------------------------
  // Shadow of the bus write and update permits
  // ------------------------------------------------------------
  logic [1:0] perm;
  logic [1:0] next_perm;
  always_comb begin
    next_perm = perm;
    if (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] &&
        AVS_ADDRESS == bief_pkg::ADDR_CTRL) begin
      next_perm = AVS_WRITEDATA[6:5];
    end
  end
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      perm <= 2'h0;
    end else begin
      perm <= next_perm;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  a_req_wait:
    assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
    else $error("waitrequest low on a new request");
  a_one_wait:
    assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=>
      !(AVS_WAITREQUEST && (AVS_READ || AVS_WRITE)))
    else $error("request not answered after one wait state");
  a_change_sends:
    assert property ($changed(SWITCH_VALUE) |-> SEND)
    else $error("switch value changed without a send");
  a_value_holds:
    assert property (!SEND |-> $stable(SEND_VALUE))
    else $error("send value moved between sends");
  a_send_pairs:
    assert property (SEND |-> SEND_VALUE == SWITCH_VALUE)
    else $error("sent value differs from object value");
  a_write_refused:
    assert property (OBJ_WRITE && !OBJ_UPDATE && !perm[0] |=>
      $stable(SWITCH_VALUE))
    else $error("refused bus write changed the object");
  a_update_refused:
    assert property (OBJ_UPDATE && !OBJ_WRITE && !perm[1] |=>
      $stable(SWITCH_VALUE))
    else $error("refused bus update changed the object");
  a_write_taken:
    assert property (OBJ_WRITE && perm[0] && OBJ_VALUE_IN != SWITCH_VALUE
      |-> ##[1:2] (SEND && SWITCH_VALUE == OBJ_VALUE_IN))
    else $error("permitted bus write not taken and sent");
endmodule

bind bief_top bief_asserts bief_asserts_inst (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .OBJ_WRITE(OBJ_WRITE),
  .OBJ_UPDATE(OBJ_UPDATE), .OBJ_VALUE_IN(OBJ_VALUE_IN), .SEND(SEND),
  .SEND_VALUE(SEND_VALUE), .SWITCH_VALUE(SWITCH_VALUE)
);

// ---- bief_bus_model.sv ----
`timescale 1ns/1ps
module bief_bus_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic send,
  output logic config_loaded,
  output logic bus_recovered,
  output logic send_delay_done,
  output logic obj_write,
  output logic obj_update,
  output logic obj_value_in
);
  int n_sent;
  int next_n_sent;
  initial begin
    {config_loaded, bus_recovered, send_delay_done} = 3'h0;
    {obj_write, obj_update, obj_value_in} = 3'h0;
  end
  // Telegrams seen on the bus
  always_comb next_n_sent = n_sent + (send ? 1 : 0);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n_sent <= 0;
    end else begin
      n_sent <= next_n_sent;
    end
  end
  // One-cycle bus event: 0 load, 1 recovery, 2 delay end, 3 write, 4 update
  task automatic pulse(input int k, input logic v);
    @(posedge clk);
    obj_value_in <= v;
    case (k)
      0: config_loaded <= 1'b1;
      1: bus_recovered <= 1'b1;
      2: send_delay_done <= 1'b1;
      3: obj_write <= 1'b1;
      default: obj_update <= 1'b1;
    endcase
    @(posedge clk);
    {config_loaded, bus_recovered, send_delay_done} <= 3'h0;
    {obj_write, obj_update} <= 2'h0;
  endtask
endmodule

// ---- bief_top_bench.sv ----
`timescale 1ns/1ps
module bief_top_bench;
  typedef struct packed {
    bief_pkg::bief_react_t r0;
    bief_pkg::bief_react_t r1;
    logic lvl;
    logic [1:0] n;
    logic v;
  } bief_row_t;
  logic CORE_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [7:0] AVS_ADDRESS = 8'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic CONTACT_IN = 1'b0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST, SEND, SEND_VALUE, SWITCH_VALUE;
  wire CONFIG_LOADED, BUS_RECOVERED, SEND_DELAY_DONE;
  wire OBJ_WRITE, OBJ_UPDATE, OBJ_VALUE_IN;
  int n_errors = 0;
  int checks = 0;
  logic [31:0] q;
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20};
  logic [31:0] re [5] = '{32'(bief_pkg::CTRL_RESET), 32'h000A000A,
    32'h0, 32'h3C, 32'h0};
  bief_row_t rows [8] = '{
    '{bief_pkg::BIEF_REACT_NONE, bief_pkg::BIEF_REACT_ON, 1, 1, 1},
    '{bief_pkg::BIEF_REACT_OFF, bief_pkg::BIEF_REACT_NONE, 0, 1, 0},
    '{bief_pkg::BIEF_REACT_NONE, bief_pkg::BIEF_REACT_TOGGLE, 1, 1, 1},
    '{bief_pkg::BIEF_REACT_TOGGLE, bief_pkg::BIEF_REACT_NONE, 0, 1, 0},
    '{bief_pkg::BIEF_REACT_ON, bief_pkg::BIEF_REACT_NONE, 1, 0, 0},
    '{bief_pkg::BIEF_REACT_ON, bief_pkg::BIEF_REACT_NONE, 0, 1, 1},
    '{bief_pkg::BIEF_REACT_NONE, bief_pkg::BIEF_REACT_STOP, 1, 0, 1},
    '{bief_pkg::BIEF_REACT_OFF, bief_pkg::BIEF_REACT_NONE, 0, 1, 0}};
  always #50 CORE_CLK = ~CORE_CLK;
  bief_top #(.MS_CYCLES(10)) bief_top_inst (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .CONTACT_IN(CONTACT_IN), .CONFIG_LOADED(CONFIG_LOADED),
    .BUS_RECOVERED(BUS_RECOVERED), .SEND_DELAY_DONE(SEND_DELAY_DONE),
    .OBJ_WRITE(OBJ_WRITE), .OBJ_UPDATE(OBJ_UPDATE),
    .OBJ_VALUE_IN(OBJ_VALUE_IN), .SEND(SEND), .SEND_VALUE(SEND_VALUE),
    .SWITCH_VALUE(SWITCH_VALUE));
  bief_bus_model bief_bus_model_inst (
    .clk(CORE_CLK), .rst_n(RESET_N), .send(SEND),
    .config_loaded(CONFIG_LOADED), .bus_recovered(BUS_RECOVERED),
    .send_delay_done(SEND_DELAY_DONE), .obj_write(OBJ_WRITE),
    .obj_update(OBJ_UPDATE), .obj_value_in(OBJ_VALUE_IN));
  // ------------------------------------------------------------
  // Checks and bus tasks
  // ------------------------------------------------------------
  task automatic test_done();
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk_int(input string s, input int e, input int g);
    checks++;
    if (e != g) begin
      n_errors++;
      $display("BAD %s exp %0d got %0d", s, e, g);
    end
  endtask
  task automatic chk_bit(input string s, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %b got %b", s, e, g);
    end
  endtask
  task automatic chk_word(input string s, input logic [31:0] e,
                          input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge CORE_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    @(posedge CORE_CLK);
    while (AVS_WAITREQUEST !== 1'b0) begin
      @(posedge CORE_CLK);
    end
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  task automatic set_contact(input logic v);
    @(posedge CORE_CLK);
    CONTACT_IN <= v;
  endtask
  task automatic sends(input int n, input int e);
    int s;
    s = bief_bus_model_inst.n_sent;
    repeat (n) @(posedge CORE_CLK);
    chk_int("sends", e, bief_bus_model_inst.n_sent - s);
  endtask
  task automatic pulse(input int k, input logic v);
    bief_bus_model_inst.pulse(k, v);
  endtask
  function automatic logic [31:0] mk(input logic [2:0] r0,
    input logic [2:0] r1, input logic [6:0] f, input logic [4:0] ls,
    input logic [1:0] cv);
    return {5'h00, cv, r1, r0, ls, 3'h3, 4'h0, f};
  endfunction
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    @(posedge CORE_CLK);
    chk_bit("SWITCH_VALUE", 1'b0, SWITCH_VALUE);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk_word("register", re[i], q);
    end
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    bus(1'b0, 8'h20, 32'h0);
    chk_word("unmapped", 32'h0, q);
    bus(1'b1, bief_pkg::ADDR_STATUS, 32'hFFFFFFFF);
    bus(1'b0, bief_pkg::ADDR_STATUS, 32'h0);
    chk_word("STATUS", 32'h0, q);
    foreach (rows[i]) begin
      bus(1'b1, bief_pkg::ADDR_CTRL,
          mk(rows[i].r0, rows[i].r1, 7'h00, 5'h03, 2'h1));
      set_contact(rows[i].lvl);
      sends(700, rows[i].n);
      chk_bit("SWITCH_VALUE", rows[i].v, SWITCH_VALUE);
      chk_bit("SEND_VALUE", rows[i].v, SEND_VALUE);
    end
    bus(1'b1, bief_pkg::ADDR_CTRL, 32'(bief_pkg::CTRL_RESET));
    set_contact(1'b1);
    sends(50, 1);
    set_contact(1'b0);
    sends(20, 0);
    set_contact(1'b1);
    sends(1000, 0);
    bus(1'b1, bief_pkg::ADDR_MINSIG, 32'h00020002);
    bus(1'b1, bief_pkg::ADDR_CTRL, 32'(bief_pkg::CTRL_RESET) | 32'h4);
    set_contact(1'b0);
    sends(600, 0);
    set_contact(1'b1);
    sends(600, 0);
    set_contact(1'b0);
    sends(900, 0);
    sends(2500, 1);
    chk_bit("SWITCH_VALUE", 1'b0, SWITCH_VALUE);
    bus(1'b1, bief_pkg::ADDR_CTRL, mk(bief_pkg::BIEF_REACT_OFF,
        bief_pkg::BIEF_REACT_ON, 7'h01, 5'h00, 2'h1));
    set_contact(1'b1);
    sends(1500, 0);
    set_contact(1'b0);
    sends(700, 1);
    chk_bit("SWITCH_VALUE", 1'b0, SWITCH_VALUE);
    set_contact(1'b1);
    sends(4500, 1);
    chk_bit("SWITCH_VALUE", 1'b1, SWITCH_VALUE);
    set_contact(1'b0);
    sends(700, 0);
    bus(1'b1, bief_pkg::ADDR_WAIT, 32'h2);
    bus(1'b1, bief_pkg::ADDR_CTRL, mk(bief_pkg::BIEF_REACT_TOGGLE,
        bief_pkg::BIEF_REACT_OFF, 7'h08, 5'h03, 2'h1));
    pulse(1, 1'b0);
    sends(100, 0);
    pulse(2, 1'b0);
    sends(20, 1);
    chk_bit("SEND_VALUE", 1'b1, SEND_VALUE);
    sends(8500, 0);
    sends(11500, 1);
    chk_bit("SWITCH_VALUE", 1'b0, SWITCH_VALUE);
    bus(1'b1, bief_pkg::ADDR_CTRL, mk(bief_pkg::BIEF_REACT_ON,
        bief_pkg::BIEF_REACT_OFF, 7'h08, 5'h03, 2'h1));
    pulse(0, 1'b0);
    sends(20, 1);
    chk_bit("SWITCH_VALUE", 1'b1, SWITCH_VALUE);
    bus(1'b1, bief_pkg::ADDR_CTRL, mk(bief_pkg::BIEF_REACT_ON,
        bief_pkg::BIEF_REACT_OFF, 7'h10, 5'h03, 2'h0));
    pulse(0, 1'b0);
    sends(11000, 0);
    pulse(3, 1'b0);
    pulse(4, 1'b0);
    sends(20, 0);
    chk_bit("SWITCH_VALUE", 1'b1, SWITCH_VALUE);
    bus(1'b1, bief_pkg::ADDR_CYCLE, 32'h1);
    bus(1'b1, bief_pkg::ADDR_CTRL, mk(bief_pkg::BIEF_REACT_ON,
        bief_pkg::BIEF_REACT_STOP, 7'h30, 5'h03, 2'h0));
    pulse(3, 1'b0);
    sends(20, 1);
    chk_bit("SWITCH_VALUE", 1'b0, SWITCH_VALUE);
    sends(20000, 2);
    set_contact(1'b1);
    sends(11000, 0);
    test_done();
  end
  initial begin
    repeat (95000) @(posedge CORE_CLK);
    n_errors++;
    test_done();
  end
endmodule
